// file: core/rpm_persist_filter.sv
`timescale 1ns/1ps
`default_nettype none
// Updates its output once the same sample repeats need_frames times
module rpm_persist_filter
	import rpm_pkg::*;
#(
	parameter int W = 1
) (
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	input  wire logic         sample_valid,
	input  wire logic [W-1:0] sample,
	input  wire logic [3:0]   need_frames,
	output var  logic [W-1:0] value_reg
);
	logic [W-1:0] cand_reg;
	logic [3:0]   run_reg;
	logic [3:0]   run_next;
	wire          same = (sample == cand_reg);

	assign run_next = !same ? 4'h1 : ((run_reg == 4'hf) ? run_reg : run_reg + 4'h1);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cand_reg  <= '0;
			run_reg   <= 4'h0;
			value_reg <= '0;
		end else if (sample_valid) begin
			cand_reg <= sample;
			run_reg  <= run_next;
			if (run_next >= need_frames)
				value_reg <= sample;
		end
	end

	value_needs_run_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(value_reg != $past(value_reg)) |-> $past(sample_valid) && ($past(run_next) >= $past(need_frames)))
		else $error("filter value changed without enough repeats");
endmodule
`default_nettype wire

// file: core/rpm_pkg.sv
// Functional notes
// - Offset change, justification events raise enabled interrupts
// - Bad pointer, flag code, justification request interrupt
// - Alignment change raises enabled interrupt
// - Ten-bit pointer split over low, high registers
// - Last size bits readable in pointer high
// - Defect states need 10 or 5 frames
// - Out-of-range bit widens flag counter enable
// - Map extension selects shadow registers
// - Label updates after repeated identical frames
// - Sixteen-bit parity error count, two bytes
// - Count write polls both counters, keeps events
// - Sixteen-bit far-end error count, two bytes
// - Global and channel addresses also poll
// - Aux defect bit, change interrupts via bit2
// - Block far-end counting for codes 1..8
// - Block or bit parity report to transmitter
// - Block or bit parity error counting
// - Size check suppresses offset change indications
// - Label filter five or three frames
// - Pointer flags set on event, clear on read
// - Spacing requires three frames since change
package rpm_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_GLOBAL_POLL   = 8'h00;
	localparam logic [7:0] IDX_CHANNEL_POLL  = 8'h07;
	localparam logic [7:0] IDX_AUX_CFG       = 8'h30;
	localparam logic [7:0] IDX_PATH_STATUS   = 8'h31;
	localparam logic [7:0] IDX_PTR_STATUS    = 8'h32;
	localparam logic [7:0] IDX_PATH_IRQ_EN   = 8'h33;
	localparam logic [7:0] IDX_PTR_IRQ_EN    = 8'h34;
	localparam logic [7:0] IDX_PTR_LOW       = 8'h35;
	localparam logic [7:0] IDX_PTR_HIGH      = 8'h36;
	localparam logic [7:0] IDX_LABEL         = 8'h37;
	localparam logic [7:0] IDX_PAR_LOW       = 8'h38;
	localparam logic [7:0] IDX_PAR_HIGH      = 8'h39;
	localparam logic [7:0] IDX_FE_LOW        = 8'h3a;
	localparam logic [7:0] IDX_FE_HIGH       = 8'h3b;
	localparam logic [7:0] IDX_DEFECT_CTRL   = 8'h3c;
	localparam logic [7:0] IDX_RING_CTRL     = 8'h3d;

	// Pointer status and enable bit positions
	localparam int BIT_FLAG_EVT   = 0;
	localparam int BIT_POS_JUST   = 1;
	localparam int BIT_NEG_JUST   = 2;
	localparam int BIT_BAD_PTR    = 3;
	localparam int BIT_BAD_FLAG   = 4;
	localparam int BIT_ALIGN_CHG  = 5;
	localparam int BIT_BAD_JUST   = 7;
	localparam logic [7:0] PTR_EVT_MASK = 8'hbf;

	// Path status and enable fields
	localparam int BIT_PATH_DEFECT = 2;

	// Pointer high fields
	localparam int BIT_OUT_OF_RANGE = 7;
	localparam int BIT_MAP_EXT      = 6;
	localparam int BIT_DEFECT_LONG  = 5;
	localparam logic [7:0] PTR_HIGH_RW_MASK = 8'he0;

	// Defect control fields
	localparam int BIT_FE_BLOCK   = 4;
	localparam int BIT_AUX_IRQ_EN = 1;
	localparam int BIT_AUX_VALUE  = 0;
	localparam logic [7:0] DEFECT_RW_MASK = 8'h36;

	// Ring control fields
	localparam int BIT_SPACING    = 7;
	localparam int BIT_SIZE_CHECK = 6;
	localparam int BIT_PAR_COUNT  = 5;
	localparam int BIT_PAR_REPORT = 3;

	// Reset values
	localparam logic [7:0] RST_BYTE    = 8'h00;
	localparam logic [9:0] RST_POINTER = 10'h000;
	localparam logic [1:0] RST_SIZE    = 2'h0;

	// Overhead byte fields
	localparam logic [1:0] SIZE_EXPECTED = 2'h2;
	localparam logic [9:0] PTR_MAX       = 10'h30e;
	localparam int G1_PATH_BIT = 3;
	localparam int G1_AUX_BIT  = 0;

	// Frame persistence thresholds
	localparam logic [3:0] DEFECT_LONG_FRAMES  = 4'ha;
	localparam logic [3:0] DEFECT_SHORT_FRAMES = 4'h5;
	localparam logic [3:0] LABEL_LONG_FRAMES   = 4'h5;
	localparam logic [3:0] LABEL_SHORT_FRAMES  = 4'h3;
	localparam logic [1:0] SPACING_FRAMES      = 2'h3;

	// Far-end block code range
	localparam logic [3:0] FE_CODE_MIN = 4'h1;
	localparam logic [3:0] FE_CODE_MAX = 4'h8;

	// Poll transfer deadline
	localparam int CLK_PERIOD_NS = 40;
	localparam int POLL_LIMIT_NS = 7000;
	localparam int POLL_LIMIT_CYC = POLL_LIMIT_NS / CLK_PERIOD_NS;

	localparam logic [15:0] COUNT_MAX = 16'hffff;
endpackage

// file: core/rpm_regs.sv
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rpm_regs
	import rpm_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// Avalon-MM slave
	input  wire logic [9:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output var  logic [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Receive overhead, one strobe per frame
	input  wire logic        frame_strobe,
	input  wire logic [7:0]  h1_byte,
	input  wire logic [7:0]  h2_byte,
	input  wire logic [7:0]  c2_byte,
	input  wire logic [7:0]  g1_byte,
	input  wire logic        bip_valid,
	input  wire logic [7:0]  bip_mismatch,
	input  wire logic        fe_valid,
	input  wire logic [3:0]  fe_code,
	// Raw pointer interpreter indications
	input  wire logic        flag_enable_raw,
	input  wire logic        inc_raw,
	input  wire logic        dec_raw,
	input  wire logic        new_ptr_raw,
	input  wire logic        bad_ptr_evt,
	input  wire logic        bad_flag_evt,
	input  wire logic        align_chg_evt,
	input  wire logic        bad_just_evt,
	input  wire logic        global_poll,
	// Qualified indications
	output var  logic        flag_enable_ind,
	output var  logic        inc_ind,
	output var  logic        dec_ind,
	output var  logic        new_ptr_ind,
	output logic             flag_count_en,
	output var  logic        tx_bip_valid,
	output var  logic [3:0]  tx_bip_count,
	output logic             path_defect_state,
	output logic             aux_defect_state,
	output logic             irq
);
	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	logic       ack_reg;
	logic [7:0] rdata_next;
	wire        req      = avs_read | avs_write;
	wire [7:0]  idx      = avs_address[9:2];
	wire        aligned  = (avs_address[1:0] == 2'h0);
	wire        do_write = avs_write & ack_reg & aligned & avs_byteenable[0];
	wire        do_read  = avs_read & ack_reg & aligned;
	wire [7:0]  wbyte    = avs_writedata[7:0];

	assign avs_waitrequest = req & ~ack_reg;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
		return a == target;
	endfunction

	function automatic logic [3:0] ones(input logic [7:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++)
			n = n + {3'h0, v[i]};
		return n;
	endfunction

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	logic [7:0] ptr_irq_en_reg;
	logic [7:0] path_irq_en_reg;
	logic [7:0] path_irq_en_shadow_reg;
	logic [7:0] aux_cfg_reg;
	logic [7:0] aux_cfg_shadow_reg;
	logic [7:0] ptr_high_ctrl_reg;
	logic [7:0] defect_ctrl_reg;
	logic [7:0] ring_ctrl_reg;

	wire map_extension_sel       = ptr_high_ctrl_reg[BIT_MAP_EXT];
	wire flag_count_out_of_range = ptr_high_ctrl_reg[BIT_OUT_OF_RANGE];
	wire defect_filter_long      = ptr_high_ctrl_reg[BIT_DEFECT_LONG];
	wire far_end_block_count     = defect_ctrl_reg[BIT_FE_BLOCK];
	wire aux_defect_irq_en       = defect_ctrl_reg[BIT_AUX_IRQ_EN];
	wire just_spacing_en         = ring_ctrl_reg[BIT_SPACING];
	wire size_check_en           = ring_ctrl_reg[BIT_SIZE_CHECK];
	wire parity_block_count      = ring_ctrl_reg[BIT_PAR_COUNT];
	wire parity_block_report     = ring_ctrl_reg[BIT_PAR_REPORT];
	wire label_filter_long       = aux_cfg_reg[0];
	wire path_defect_irq_en      = path_irq_en_reg[BIT_PATH_DEFECT];

	wire wr_normal_33 = do_write & hit(idx, IDX_PATH_IRQ_EN) & ~map_extension_sel;
	wire wr_shadow_33 = do_write & hit(idx, IDX_PATH_IRQ_EN) & map_extension_sel;
	wire wr_normal_30 = do_write & hit(idx, IDX_AUX_CFG) & ~map_extension_sel;
	wire wr_shadow_30 = do_write & hit(idx, IDX_AUX_CFG) & map_extension_sel;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_reg                <= 1'b0;
			ptr_irq_en_reg         <= RST_BYTE;
			path_irq_en_reg        <= RST_BYTE;
			path_irq_en_shadow_reg <= RST_BYTE;
			aux_cfg_reg            <= RST_BYTE;
			aux_cfg_shadow_reg     <= RST_BYTE;
			ptr_high_ctrl_reg      <= RST_BYTE;
			defect_ctrl_reg        <= RST_BYTE;
			ring_ctrl_reg          <= RST_BYTE;
			avs_readdata           <= 32'h0;
		end else begin
			ack_reg <= req & ~ack_reg;
			if (req & ~ack_reg)
				avs_readdata <= {24'h0, rdata_next};
			if (do_write & hit(idx, IDX_PTR_IRQ_EN))
				ptr_irq_en_reg <= wbyte;
			if (wr_normal_33)
				path_irq_en_reg <= wbyte;
			if (wr_shadow_33)
				path_irq_en_shadow_reg <= wbyte;
			if (wr_normal_30)
				aux_cfg_reg <= wbyte;
			if (wr_shadow_30)
				aux_cfg_shadow_reg <= wbyte;
			if (do_write & hit(idx, IDX_PTR_HIGH))
				ptr_high_ctrl_reg <= wbyte & PTR_HIGH_RW_MASK;
			if (do_write & hit(idx, IDX_DEFECT_CTRL))
				defect_ctrl_reg <= wbyte & DEFECT_RW_MASK;
			if (do_write & hit(idx, IDX_RING_CTRL))
				ring_ctrl_reg <= wbyte;
		end
	end

	// ------------------------------------------------------------
	// Pointer qualification
	// ------------------------------------------------------------
	logic [9:0] ptr_reg;
	logic [1:0] size_reg;
	logic [1:0] since_chg_reg;
	wire [9:0] rx_offset = {h1_byte[1:0], h2_byte};
	wire [1:0] rx_size   = h1_byte[3:2];
	wire size_ok    = ~size_check_en | (rx_size == SIZE_EXPECTED);
	wire spacing_ok = ~just_spacing_en | (since_chg_reg >= SPACING_FRAMES);
	wire in_range   = (rx_offset <= PTR_MAX);
	wire flag_q     = flag_enable_raw & size_ok & in_range;
	wire inc_q      = inc_raw & size_ok & spacing_ok;
	wire dec_q      = dec_raw & size_ok & spacing_ok;
	wire newp_q     = new_ptr_raw & size_ok;
	wire offset_chg = flag_q | inc_q | dec_q;

	assign flag_count_en = flag_enable_raw & size_ok & (flag_count_out_of_range | in_range);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ptr_reg         <= RST_POINTER;
			size_reg        <= RST_SIZE;
			since_chg_reg   <= 2'h0;
			flag_enable_ind <= 1'b0;
			inc_ind         <= 1'b0;
			dec_ind         <= 1'b0;
			new_ptr_ind     <= 1'b0;
		end else begin
			flag_enable_ind <= flag_q;
			inc_ind         <= inc_q;
			dec_ind         <= dec_q;
			new_ptr_ind     <= newp_q;
			if (frame_strobe)
				size_reg <= rx_size;
			if (offset_chg)
				since_chg_reg <= 2'h0;
			else if (frame_strobe && since_chg_reg != SPACING_FRAMES)
				since_chg_reg <= since_chg_reg + 2'h1;
			if (flag_q)
				ptr_reg <= rx_offset;
			else if (inc_q)
				ptr_reg <= (ptr_reg >= PTR_MAX) ? RST_POINTER : ptr_reg + 10'h1;
			else if (dec_q)
				ptr_reg <= (ptr_reg == RST_POINTER) ? PTR_MAX : ptr_reg - 10'h1;
		end
	end

	size_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(size_check_en && rx_size != SIZE_EXPECTED) |=> !flag_enable_ind && !inc_ind && !dec_ind && !new_ptr_ind)
		else $error("indication passed with bad size bits");
	spacing_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(just_spacing_en && since_chg_reg < SPACING_FRAMES) |=> !inc_ind && !dec_ind)
		else $error("justification followed too soon");
	flag_range_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(flag_enable_raw && size_ok && !in_range) |-> (flag_count_en == flag_count_out_of_range))
		else $error("flag counter enable ignores out-of-range bit");

	// ------------------------------------------------------------
	// Defect and label filters
	// ------------------------------------------------------------
	wire [3:0] defect_need = defect_filter_long ? DEFECT_LONG_FRAMES : DEFECT_SHORT_FRAMES;
	wire [3:0] label_need  = label_filter_long ? LABEL_LONG_FRAMES : LABEL_SHORT_FRAMES;
	logic [7:0] signal_label_value;

	rpm_persist_filter #(.W(1)) u_path_defect (
		.sys_clk      (sys_clk),
		.rst_n        (rst_n),
		.sample_valid (frame_strobe),
		.sample       (g1_byte[G1_PATH_BIT]),
		.need_frames  (defect_need),
		.value_reg    (path_defect_state)
	);
	rpm_persist_filter #(.W(1)) u_aux_defect (
		.sys_clk      (sys_clk),
		.rst_n        (rst_n),
		.sample_valid (frame_strobe),
		.sample       (g1_byte[G1_AUX_BIT]),
		.need_frames  (defect_need),
		.value_reg    (aux_defect_state)
	);
	rpm_persist_filter #(.W(8)) u_label (
		.sys_clk      (sys_clk),
		.rst_n        (rst_n),
		.sample_valid (frame_strobe),
		.sample       (c2_byte),
		.need_frames  (label_need),
		.value_reg    (signal_label_value)
	);

	// ------------------------------------------------------------
	// Interrupt status
	// ------------------------------------------------------------
	logic [7:0] ptr_status_reg;
	logic       path_defect_irq_status;
	logic       prev_path_reg;
	logic       prev_aux_reg;
	logic [7:0] ptr_evt;
	wire rd_ptr_status  = do_read & hit(idx, IDX_PTR_STATUS);
	wire rd_path_status = do_read & hit(idx, IDX_PATH_STATUS) & ~map_extension_sel & avs_readdata[BIT_PATH_DEFECT];
	wire path_chg = (path_defect_state != prev_path_reg) & path_defect_irq_en;
	wire aux_chg  = (aux_defect_state != prev_aux_reg) & aux_defect_irq_en;

	always_comb begin
		ptr_evt                = 8'h00;
		ptr_evt[BIT_FLAG_EVT]  = flag_q;
		ptr_evt[BIT_POS_JUST]  = inc_q;
		ptr_evt[BIT_NEG_JUST]  = dec_q;
		ptr_evt[BIT_BAD_PTR]   = bad_ptr_evt;
		ptr_evt[BIT_BAD_FLAG]  = bad_flag_evt;
		ptr_evt[BIT_ALIGN_CHG] = align_chg_evt;
		ptr_evt[BIT_BAD_JUST]  = bad_just_evt;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ptr_status_reg         <= RST_BYTE;
			path_defect_irq_status <= 1'b0;
			prev_path_reg          <= 1'b0;
			prev_aux_reg           <= 1'b0;
		end else begin
			prev_path_reg          <= path_defect_state;
			prev_aux_reg           <= aux_defect_state;
			ptr_status_reg <= (ptr_status_reg & ~(rd_ptr_status ? avs_readdata[7:0] : RST_BYTE)) | ptr_evt;
			path_defect_irq_status <= (path_defect_irq_status & ~rd_path_status) | path_chg | aux_chg;
		end
	end

	assign irq = (|(ptr_status_reg & ptr_irq_en_reg & PTR_EVT_MASK)) | path_defect_irq_status;

	event_sets_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(ptr_evt != 8'h00) |=> (ptr_status_reg & $past(ptr_evt)) == $past(ptr_evt))
		else $error("pointer event lost");
	read_clears_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(rd_ptr_status && ptr_evt == 8'h00) |=> (ptr_status_reg & $past(avs_readdata[7:0])) == 8'h00)
		else $error("status read did not clear flags");
	irq_follows_en_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(ptr_status_reg[BIT_POS_JUST] && ptr_irq_en_reg[BIT_POS_JUST]) |-> irq)
		else $error("enabled flag without interrupt");
	aux_change_irq_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(aux_defect_irq_en && $changed(aux_defect_state)) |=> path_defect_irq_status && irq)
		else $error("aux defect change lost");

	// ------------------------------------------------------------
	// Error counters
	// ------------------------------------------------------------
	logic [15:0] par_acc_reg;
	logic [15:0] fe_acc_reg;
	logic [15:0] parity_error_count;
	logic [15:0] far_end_error_count;
	wire [3:0] bip_ones = ones(bip_mismatch);
	wire [3:0] par_inc  = !bip_valid ? 4'h0 :
		(parity_block_count ? {3'h0, |bip_mismatch} : bip_ones);
	wire       fe_in    = (fe_code >= FE_CODE_MIN) && (fe_code <= FE_CODE_MAX);
	wire [3:0] fe_inc   = !(fe_valid && fe_in) ? 4'h0 :
		(far_end_block_count ? 4'h1 : fe_code);
	wire poll = do_write & (hit(idx, IDX_PAR_LOW) | hit(idx, IDX_PAR_HIGH) | hit(idx, IDX_FE_LOW)
		| hit(idx, IDX_FE_HIGH) | hit(idx, IDX_GLOBAL_POLL) | hit(idx, IDX_CHANNEL_POLL))
		| global_poll;

	function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [3:0] b);
		logic [16:0] s;
		s = {1'b0, a} + {13'h0, b};
		return s[16] ? COUNT_MAX : s[15:0];
	endfunction

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			par_acc_reg         <= 16'h0;
			fe_acc_reg          <= 16'h0;
			parity_error_count  <= 16'h0;
			far_end_error_count <= 16'h0;
			tx_bip_valid        <= 1'b0;
			tx_bip_count        <= 4'h0;
		end else begin
			tx_bip_valid <= bip_valid;
			tx_bip_count <= parity_block_report ? {3'h0, |bip_mismatch} : bip_ones;
			if (poll) begin
				parity_error_count  <= par_acc_reg;
				far_end_error_count <= fe_acc_reg;
				par_acc_reg         <= {12'h0, par_inc};
				fe_acc_reg          <= {12'h0, fe_inc};
			end else begin
				par_acc_reg <= sat_add(par_acc_reg, par_inc);
				fe_acc_reg  <= sat_add(fe_acc_reg, fe_inc);
			end
		end
	end

	poll_transfer_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		poll |=> (parity_error_count == $past(par_acc_reg)) && (far_end_error_count == $past(fe_acc_reg))
			&& (par_acc_reg == {12'h0, $past(par_inc)}))
		else $error("poll did not transfer counts");
	poll_restart_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		poll |=> fe_acc_reg == {12'h0, $past(fe_inc)})
		else $error("poll lost a coincident far-end event");
	fe_block_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(far_end_block_count && fe_valid && fe_code > FE_CODE_MAX) |-> fe_inc == 4'h0)
		else $error("invalid far-end code counted");
	par_report_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(parity_block_report && bip_valid && bip_mismatch != 8'h00) |=> tx_bip_count == 4'h1)
		else $error("block parity report not single");

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	always_comb begin
		rdata_next = 8'h00;
		if (aligned) begin
			case (idx)
				IDX_AUX_CFG:     rdata_next = map_extension_sel ? aux_cfg_shadow_reg : aux_cfg_reg;
				IDX_PATH_STATUS: rdata_next = map_extension_sel ? 8'h00
					: {5'h0, path_defect_irq_status, 2'h0};
				IDX_PTR_STATUS:  rdata_next = ptr_status_reg;
				IDX_PATH_IRQ_EN: rdata_next = map_extension_sel ? path_irq_en_shadow_reg : path_irq_en_reg;
				IDX_PTR_IRQ_EN:  rdata_next = ptr_irq_en_reg;
				IDX_PTR_LOW:     rdata_next = ptr_reg[7:0];
				IDX_PTR_HIGH:    rdata_next = {ptr_high_ctrl_reg[7:5], 1'b0, size_reg, ptr_reg[9:8]};
				IDX_LABEL:       rdata_next = signal_label_value;
				IDX_PAR_LOW:     rdata_next = parity_error_count[7:0];
				IDX_PAR_HIGH:    rdata_next = parity_error_count[15:8];
				IDX_FE_LOW:      rdata_next = far_end_error_count[7:0];
				IDX_FE_HIGH:     rdata_next = far_end_error_count[15:8];
				IDX_DEFECT_CTRL: rdata_next = {defect_ctrl_reg[7:1], aux_defect_state};
				IDX_RING_CTRL:   rdata_next = ring_ctrl_reg;
				default:         rdata_next = 8'h00;
			endcase
		end
	end

	bus_answer_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(req && avs_waitrequest) |=> !avs_waitrequest)
		else $error("bus answer late");
endmodule
`default_nettype wire

// file: test/rpm_far_end.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Far-end path source, one frame per call
// ----------------------------------------
module rpm_far_end
	import rpm_pkg::*;
(
	input  wire logic       sys_clk,
	output var  logic       frame_strobe,
	output var  logic [7:0] h1_byte,
	output var  logic [7:0] h2_byte,
	output var  logic [7:0] c2_byte,
	output var  logic [7:0] g1_byte,
	output var  logic       bip_valid,
	output var  logic [7:0] bip_mismatch,
	output var  logic       fe_valid,
	output var  logic [3:0] fe_code
);
	initial begin
		{frame_strobe, bip_valid, fe_valid} = 3'h0;
		{h1_byte, h2_byte, c2_byte, g1_byte, bip_mismatch, fe_code} = 44'h0;
	end
	// Bytes invert between frames so stale values never look valid
	task send(input logic [7:0] a, b, c, g, m, input logic [3:0] f);
		{frame_strobe, bip_valid, fe_valid} <= 3'h7;
		{h1_byte, h2_byte, c2_byte, g1_byte, bip_mismatch, fe_code} <= {a, b, c, g, m, f};
		@(posedge sys_clk);
		{frame_strobe, bip_valid, fe_valid} <= 3'h0;
		{h1_byte, h2_byte, c2_byte, g1_byte, bip_mismatch, fe_code} <= ~{a, b, c, g, m, f};
		@(posedge sys_clk);
	endtask
endmodule
`default_nettype wire

// file: test/tb_rx_path_overhead_monitor_regs.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; $display("unexpected at %0t got %h exp %h", $time, g, e); end end
module tb_rx_path_overhead_monitor_regs
	import rpm_pkg::*;
;
	logic        sys_clk, rst_n, avs_read, avs_write, avs_waitrequest, frame_strobe, bip_valid, fe_valid;
	logic        bad_ptr_evt, bad_flag_evt, align_chg_evt, bad_just_evt, global_poll, tx_bip_valid;
	logic        path_defect_state, aux_defect_state, irq;
	logic [9:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [7:0]  h1_byte, h2_byte, c2_byte, g1_byte, bip_mismatch, rd;
	logic [3:0]  fe_code, tx_bip_count, last_bip, ind;
	int          num_errors, n_compared, cyc;
	logic        last_fc;
	wire  [4:0]  qual;

	rpm_regs i_dut (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .frame_strobe, .h1_byte, .h2_byte,
		.c2_byte, .g1_byte, .bip_valid, .bip_mismatch, .fe_valid, .fe_code, .flag_enable_raw(ind[0]),
		.inc_raw(ind[1]), .dec_raw(ind[2]), .new_ptr_raw(ind[3]), .bad_ptr_evt, .bad_flag_evt,
		.align_chg_evt, .bad_just_evt, .global_poll, .flag_enable_ind(qual[0]), .inc_ind(qual[1]),
		.dec_ind(qual[2]), .new_ptr_ind(qual[3]), .flag_count_en(qual[4]), .tx_bip_valid, .tx_bip_count,
		.path_defect_state,
		.aux_defect_state, .irq);
	rpm_far_end i_far (.sys_clk, .frame_strobe, .h1_byte, .h2_byte, .c2_byte, .g1_byte, .bip_valid,
		.bip_mismatch, .fe_valid, .fe_code);

	// ----------------------------------------
	// Clock, timeout, report
	// ----------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (tx_bip_valid === 1'b1) last_bip <= tx_bip_count;
		if (frame_strobe === 1'b1) last_fc <= qual[4];
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			end_of_test();
		end
	end
	task end_of_test;
		$display("compared %0d mismatched %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// ----------------------------------------
	// Bus and frame drivers
	// ----------------------------------------
	task bus(input logic wr, input logic [7:0] idx, wd);
		avs_address <= {idx, 2'b00};
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= {24'h0, wd};
		@(posedge sys_clk iff avs_waitrequest === 1'b0);
		rd = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge sys_clk);
	endtask
	task wr(input logic [7:0] i, d); bus(1'b1, i, d); endtask
	task chk_rd(input logic [7:0] i, e); bus(1'b0, i, 8'h00); `CHK(rd, e) endtask
	task frm(input logic [7:0] a, b, c, g, m, input logic [3:0] f, e);
		fork
			i_far.send(a, b, c, g, m, f);
			begin ind <= e; @(posedge sys_clk); ind <= 4'h0; end
		join
	endtask
	task pulse4(input logic [3:0] e);
		{bad_just_evt, align_chg_evt, bad_flag_evt, bad_ptr_evt} <= e;
		@(posedge sys_clk);
		{bad_just_evt, align_chg_evt, bad_flag_evt, bad_ptr_evt} <= 4'h0;
		@(posedge sys_clk);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_regs;
		chk_rd(IDX_RING_CTRL, RST_BYTE);
		chk_rd(8'h3e, 8'h00);
		wr(IDX_RING_CTRL, 8'ha8);
		chk_rd(IDX_RING_CTRL, 8'ha8);
		wr(IDX_RING_CTRL, 8'h00);
	endtask
	task t_ptr_irq;
		pulse4(4'h1);
		`CHK(irq, 1'b0)
		chk_rd(IDX_PTR_STATUS, 8'h08);
		wr(IDX_PTR_IRQ_EN, PTR_EVT_MASK);
		pulse4(4'hf);
		`CHK(irq, 1'b1)
		chk_rd(IDX_PTR_STATUS, 8'hb8);
		`CHK(irq, 1'b0)
	endtask
	task t_pointer;
		frm(8'h69, 8'h23, 0, 0, 0, 0, 4'h1);
		`CHK(qual[3:0], 4'h1)
		chk_rd(IDX_PTR_STATUS, 8'h01);
		chk_rd(IDX_PTR_LOW, 8'h23);
		chk_rd(IDX_PTR_HIGH, 8'h09);
		chk_rd(IDX_PTR_STATUS, 8'h00);
		frm(8'h69, 8'h23, 0, 0, 0, 0, 4'h2);
		chk_rd(IDX_PTR_LOW, 8'h24);
		chk_rd(IDX_PTR_STATUS, 8'h02);
		frm(8'h69, 8'h24, 0, 0, 0, 0, 4'h8);
		`CHK(qual[3:0], 4'h8)
		wr(IDX_RING_CTRL, 8'h40);
		frm(8'h65, 8'h24, 0, 0, 0, 0, 4'hc);
		`CHK(qual[3:0], 4'h0)
		chk_rd(IDX_PTR_LOW, 8'h24);
		wr(IDX_RING_CTRL, 8'hc0);
		frm(8'h69, 8'h24, 0, 0, 0, 0, 4'h4);
		chk_rd(IDX_PTR_LOW, 8'h24);
		repeat (3) frm(8'h69, 8'h24, 0, 0, 0, 0, 4'h0);
		frm(8'h69, 8'h24, 0, 0, 0, 0, 4'h4);
		chk_rd(IDX_PTR_LOW, 8'h23);
		chk_rd(IDX_PTR_STATUS, 8'h04);
		wr(IDX_RING_CTRL, 8'h00);
		wr(IDX_PTR_HIGH, 8'h80);
		frm(8'h6b, 8'h10, 0, 0, 0, 0, 4'h1);
		`CHK({last_fc, qual[0]}, 2'h2)
		wr(IDX_PTR_HIGH, 8'h00);
		frm(8'h6b, 8'h10, 0, 0, 0, 0, 4'h1);
		`CHK(last_fc, 1'b0)
		chk_rd(IDX_PTR_LOW, 8'h23);
	endtask
	task t_filters;
		wr(IDX_DEFECT_CTRL, 8'h02);
		repeat (2) frm(8'h69, 8'h23, 8'h13, 8'h09, 0, 0, 0);
		chk_rd(IDX_LABEL, 8'h00);
		frm(8'h69, 8'h23, 8'h13, 8'h09, 0, 0, 0);
		chk_rd(IDX_LABEL, 8'h13);
		frm(8'h69, 8'h23, 8'h13, 8'h09, 0, 0, 0);
		`CHK(path_defect_state, 1'b0)
		frm(8'h69, 8'h23, 8'h13, 8'h09, 0, 0, 0);
		`CHK({path_defect_state, aux_defect_state}, 2'h3)
		@(posedge sys_clk);
		`CHK(irq, 1'b1)
		chk_rd(IDX_DEFECT_CTRL, 8'h03);
		chk_rd(IDX_PATH_STATUS, 8'h04);
	endtask
	task t_counts;
		frm(0, 0, 0, 0, 8'h0b, 4'h5, 0);
		@(posedge sys_clk);
		`CHK(last_bip, 4'h3)
		frm(0, 0, 0, 0, 8'h0b, 4'h5, 0);
		frm(0, 0, 0, 0, 8'h00, 4'h9, 0);
		wr(IDX_PAR_LOW, 8'h00);
		chk_rd(IDX_PAR_LOW, 8'h06);
		chk_rd(IDX_PAR_HIGH, 8'h00);
		chk_rd(IDX_FE_LOW, 8'h0a);
		chk_rd(IDX_FE_HIGH, 8'h00);
		wr(IDX_RING_CTRL, 8'h28);
		wr(IDX_DEFECT_CTRL, 8'h12);
		frm(0, 0, 0, 0, 8'h0b, 4'h5, 0);
		@(posedge sys_clk);
		`CHK(last_bip, 4'h1)
		frm(0, 0, 0, 0, 8'h00, 4'h9, 0);
		global_poll <= 1'b1;
		@(posedge sys_clk);
		global_poll <= 1'b0;
		@(posedge sys_clk);
		chk_rd(IDX_PAR_LOW, 8'h01);
		chk_rd(IDX_FE_LOW, 8'h01);
		wr(IDX_CHANNEL_POLL, 8'h00);
		chk_rd(IDX_PAR_LOW, 8'h00);
		chk_rd(IDX_FE_LOW, 8'h00);
		frm(0, 0, 0, 0, 8'h01, 4'h1, 0);
		wr(IDX_GLOBAL_POLL, 8'h00);
		chk_rd(IDX_PAR_LOW, 8'h01);
		chk_rd(IDX_FE_LOW, 8'h01);
	endtask
	task t_shadow;
		wr(IDX_PTR_HIGH, 8'h40);
		wr(IDX_AUX_CFG, 8'h5a);
		chk_rd(IDX_AUX_CFG, 8'h5a);
		wr(IDX_PTR_HIGH, 8'h00);
		chk_rd(IDX_AUX_CFG, 8'h00);
	endtask

	initial begin
		{rst_n, avs_read, avs_write, global_poll, ind} = 8'h0;
		{bad_ptr_evt, bad_flag_evt, align_chg_evt, bad_just_evt} = 4'h0;
		{avs_address, avs_writedata} = 42'h0;
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		t_regs();
		t_ptr_irq();
		t_pointer();
		t_filters();
		t_counts();
		t_shadow();
		end_of_test();
	end
endmodule
`default_nettype wire
